// ---- design/atomr_map.svh ----
// register offsets, field positions, reset values and timing counts
// assumes inclusion by bare name from the register design file; the package does not include it
`ifndef ATOMR_MAP_SVH
`define ATOMR_MAP_SVH
// ****************************************************************
// register addresses (7-bit)
// ****************************************************************
`define ATOMR_ADDR_RESET      7'h00
`define ATOMR_ADDR_TIMING     7'h02
`define ATOMR_ADDR_OUTMODE    7'h03
// ****************************************************************
// field positions
// ****************************************************************
`define ATOMR_SWRST_BIT       7
`define ATOMR_INVERT_BIT      3
`define ATOMR_PHASE_HI        2
`define ATOMR_PHASE_LO        1
`define ATOMR_STAB_BIT        0
`define ATOMR_CUR_HI          6
`define ATOMR_CUR_LO          4
`define ATOMR_TERM_BIT        3
`define ATOMR_HIZ_BIT         2
`define ATOMR_FMT_HI          1
`define ATOMR_FMT_LO          0
// ****************************************************************
// write masks and reset values
// ****************************************************************
`define ATOMR_TIMING_MASK     8'h0F
`define ATOMR_OUTMODE_MASK    8'h7F
`define ATOMR_REG_RESET       8'h00
// ****************************************************************
// frame and current scaling
// ****************************************************************
`define ATOMR_FRAME_BITS      5'h10
`define ATOMR_CUR_UNUSED      3'h3
// current in units of 0.05 mA; termination scales by 16/10
`define ATOMR_TERM_NUM        13'h0010
`define ATOMR_TERM_DEN        13'h000A
`endif

// ---- design/atomr_pkg.sv ----
// types for the timing and output mode register block
// assumes the map header sits alongside
package atomr_pkg;
    typedef enum logic [1:0] {
        ATOMR_FMT_FULL_SE = 2'b00,
        ATOMR_FMT_DDR_DIFF = 2'b01,
        ATOMR_FMT_DDR_SE  = 2'b10,
        ATOMR_FMT_UNUSED  = 2'b11
    } atomr_fmt_e;
    typedef enum logic [1:0] {
        ATOMR_PH_0   = 2'b00,
        ATOMR_PH_45  = 2'b01,
        ATOMR_PH_90  = 2'b10,
        ATOMR_PH_135 = 2'b11
    } atomr_phase_e;
    typedef logic [7:0] atomr_byte_t;
endpackage

// ---- design/atomr_regs.sv ----
// timing and output mode registers behind a 16-bit serial port
// assumes i_ser_clk is the host's serial clock, running only in frames
`include "atomr_map.svh"
`timescale 1ns/1ps
`default_nettype none
module atomr_regs
    import atomr_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_reset,
    input  wire logic        i_clk_en,
    input  wire logic        i_ser_clk,
    input  wire logic        i_ser_cs_n,
    input  wire logic        i_ser_sdi,
    output logic             o_sdo_out,
    output logic             o_sdo_oe,
    output logic             o_out_clk_invert,
    output logic [1:0]       o_out_clk_phase_delay,
    output logic             o_duty_cycle_stabilizer_en,
    output logic [2:0]       o_diff_driver_current_sel,
    output logic             o_internal_termination_en,
    output logic             o_outputs_high_z,
    output logic [1:0]       o_output_format_sel,
    output logic [12:0]      o_drive_current_q,
    output logic             o_phase_without_stab,
    output logic             o_format_unused,
    output logic             o_current_unused
);
    // ****************************************************************
    // serial domain: shift in frame, shift out read data
    // ****************************************************************
    logic [4:0]  bit_cnt;
    logic [14:0] shift_in;
    logic [7:0]  rd_shift;
    logic        rd_cmd;
    logic [15:0] frame_word;
    logic        frame_tgl;
    logic        sdo_low;

    // reset by cs high asynchronously: the serial clock stops between frames
    always_ff @(posedge i_ser_clk or posedge i_ser_cs_n) begin
        if (i_ser_cs_n) begin
            bit_cnt  <= 5'h00;
            shift_in <= 15'h0000;
            rd_cmd   <= 1'b0;
        end else if (bit_cnt != `ATOMR_FRAME_BITS) begin
            bit_cnt  <= bit_cnt + 5'h01;
            shift_in <= {shift_in[13:0], i_ser_sdi};
            if (bit_cnt == 5'h00) begin
                rd_cmd <= i_ser_sdi;
            end
        end
    end

    // completed frame captured; toggle tells the system domain
    always_ff @(posedge i_ser_clk or posedge i_reset) begin
        if (i_reset) begin
            frame_word <= 16'h0000;
            frame_tgl  <= 1'b0;
        end else if (!i_ser_cs_n && bit_cnt == 5'h0F) begin
            frame_word <= {shift_in, i_ser_sdi};
            frame_tgl  <= ~frame_tgl;
        end
    end

    // read data loaded after the address; taken from synchronised copies
    logic [7:0] rd_value;
    always_ff @(negedge i_ser_clk or posedge i_ser_cs_n) begin
        if (i_ser_cs_n) begin
            rd_shift <= 8'h00;
            sdo_low  <= 1'b0;
        end else if (bit_cnt == 5'h08) begin
            rd_shift <= {rd_value[6:0], 1'b0};
            sdo_low  <= rd_cmd & ~rd_value[7];
        end else if (bit_cnt > 5'h08 && bit_cnt < `ATOMR_FRAME_BITS) begin
            rd_shift <= {rd_shift[6:0], 1'b0};
            sdo_low  <= rd_cmd & ~rd_shift[7];
        end else begin
            sdo_low  <= 1'b0;
        end
    end

    // open drain: only pulls low
    assign o_sdo_out = 1'b0;
    assign o_sdo_oe  = sdo_low;

    // ****************************************************************
    // system domain: toggle sync and register update
    // ****************************************************************
    logic [2:0] tgl_sync;
    logic       frame_done;
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            tgl_sync <= 3'h0;
        end else if (i_clk_en) begin
            tgl_sync <= {tgl_sync[1:0], frame_tgl};
        end
    end
    assign frame_done = tgl_sync[2] ^ tgl_sync[1];

    // frame_word is stable for a whole frame after the toggle moves
    logic       wr_flag;
    logic [6:0] wr_addr;
    logic [7:0] wr_data;
    assign wr_flag = frame_word[15];
    assign wr_addr = frame_word[14:8];
    assign wr_data = frame_word[7:0];

    atomr_byte_t timing_reg;
    atomr_byte_t outmode_reg;
    logic        do_write;
    logic        sw_reset;
    assign do_write = frame_done && !wr_flag;
    assign sw_reset = do_write && wr_addr == `ATOMR_ADDR_RESET
                      && wr_data[`ATOMR_SWRST_BIT];

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            timing_reg  <= `ATOMR_REG_RESET;
            outmode_reg <= `ATOMR_REG_RESET;
        end else if (i_clk_en) begin
            if (sw_reset) begin
                timing_reg  <= `ATOMR_REG_RESET;
                outmode_reg <= `ATOMR_REG_RESET;
            end else if (do_write && wr_addr == `ATOMR_ADDR_TIMING) begin
                timing_reg  <= wr_data & `ATOMR_TIMING_MASK;
            end else if (do_write && wr_addr == `ATOMR_ADDR_OUTMODE) begin
                outmode_reg <= wr_data & `ATOMR_OUTMODE_MASK;
            end
        end
    end

    // read-back value crosses as a quasi-static word, double registered
    logic [7:0] rd_sync1;
    logic [7:0] rd_sync2;
    logic [7:0] timing_q;
    logic [7:0] outmode_q;
    logic [6:0] addr_live;
    assign addr_live = shift_in[6:0];
    always_ff @(posedge i_ser_clk or posedge i_reset) begin
        if (i_reset) begin
            rd_sync1  <= 8'h00;
            timing_q  <= 8'h00;
            outmode_q <= 8'h00;
            rd_sync2  <= 8'h00;
        end else begin
            rd_sync1  <= timing_reg;
            timing_q  <= rd_sync1;
            rd_sync2  <= outmode_reg;
            outmode_q <= rd_sync2;
        end
    end
    assign rd_value = (addr_live == `ATOMR_ADDR_TIMING)  ? timing_q :
                      (addr_live == `ATOMR_ADDR_OUTMODE) ? outmode_q :
                      8'h00;

    // ****************************************************************
    // decoded controls, all registered
    // ****************************************************************
    logic [12:0] base_current;
    always_comb begin
        unique case (outmode_reg[`ATOMR_CUR_HI:`ATOMR_CUR_LO])
            3'h0:    base_current = 13'h0046;
            3'h1:    base_current = 13'h0050;
            3'h2:    base_current = 13'h005A;
            3'h3:    base_current = 13'h0046;
            3'h4:    base_current = 13'h003C;
            3'h5:    base_current = 13'h0032;
            3'h6:    base_current = 13'h002A;
            default: base_current = 13'h0023;
        endcase
    end

    logic [12:0] next_drive_current;
    always_comb begin
        if (outmode_reg[`ATOMR_TERM_BIT]) begin
            next_drive_current = 13'((base_current * `ATOMR_TERM_NUM)
                                      / `ATOMR_TERM_DEN);
        end else begin
            next_drive_current = base_current;
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_out_clk_invert           <= 1'b0;
            o_out_clk_phase_delay      <= 2'h0;
            o_duty_cycle_stabilizer_en <= 1'b0;
            o_diff_driver_current_sel  <= 3'h0;
            o_internal_termination_en  <= 1'b0;
            o_outputs_high_z           <= 1'b0;
            o_output_format_sel        <= 2'h0;
            o_drive_current_q          <= 13'h0046;
            o_phase_without_stab       <= 1'b0;
            o_format_unused            <= 1'b0;
            o_current_unused           <= 1'b0;
        end else if (i_clk_en) begin
            o_out_clk_invert <= timing_reg[`ATOMR_INVERT_BIT];
            o_out_clk_phase_delay <=
                timing_reg[`ATOMR_PHASE_HI:`ATOMR_PHASE_LO];
            o_duty_cycle_stabilizer_en <= timing_reg[`ATOMR_STAB_BIT];
            o_diff_driver_current_sel <=
                outmode_reg[`ATOMR_CUR_HI:`ATOMR_CUR_LO];
            o_internal_termination_en <= outmode_reg[`ATOMR_TERM_BIT];
            o_outputs_high_z <= outmode_reg[`ATOMR_HIZ_BIT];
            o_output_format_sel <=
                outmode_reg[`ATOMR_FMT_HI:`ATOMR_FMT_LO];
            o_drive_current_q <= next_drive_current;
            // flags a host that broke the stabilizer pairing
            o_phase_without_stab <=
                (timing_reg[`ATOMR_PHASE_HI:`ATOMR_PHASE_LO] != 2'h0)
                && !timing_reg[`ATOMR_STAB_BIT];
            o_format_unused <= outmode_reg[`ATOMR_FMT_HI:`ATOMR_FMT_LO]
                               == ATOMR_FMT_UNUSED;
            o_current_unused <= outmode_reg[`ATOMR_CUR_HI:`ATOMR_CUR_LO]
                                == `ATOMR_CUR_UNUSED;
        end
    end

    // ****************************************************************
    // assertions
    // ****************************************************************
    sequence s_wr_timing;
        i_clk_en && do_write && !sw_reset
        && wr_addr == `ATOMR_ADDR_TIMING;
    endsequence
    sequence s_wr_outmode;
        i_clk_en && do_write && !sw_reset
        && wr_addr == `ATOMR_ADDR_OUTMODE;
    endsequence

    property p_timing_wr;
        @(posedge i_clk) disable iff (i_reset)
        s_wr_timing |=> timing_reg == ($past(wr_data) & 8'h0F);
    endproperty
    a_timing_wr: assert property (p_timing_wr)
        else $error("timing register not written");

    property p_outmode_wr;
        @(posedge i_clk) disable iff (i_reset)
        s_wr_outmode |=> outmode_reg == ($past(wr_data) & 8'h7F);
    endproperty
    a_outmode_wr: assert property (p_outmode_wr)
        else $error("output mode register not written");

    property p_unused_zero;
        @(posedge i_clk) disable iff (i_reset)
        timing_reg[7:4] == 4'h0 && !outmode_reg[7];
    endproperty
    a_unused_zero: assert property (p_unused_zero)
        else $error("unused bit set");

    property p_read_keeps;
        @(posedge i_clk) disable iff (i_reset)
        (i_clk_en && frame_done && wr_flag) |=>
            $stable(timing_reg) && $stable(outmode_reg);
    endproperty
    a_read_keeps: assert property (p_read_keeps)
        else $error("read-back changed a register");

    property p_swreset;
        @(posedge i_clk) disable iff (i_reset)
        (i_clk_en && sw_reset) |=> timing_reg == 8'h00
            && outmode_reg == 8'h00;
    endproperty
    a_swreset: assert property (p_swreset)
        else $error("software reset did not clear");

    property p_invert;
        @(posedge i_clk) disable iff (i_reset)
        i_clk_en |=> o_out_clk_invert == $past(timing_reg[3]);
    endproperty
    a_invert: assert property (p_invert)
        else $error("clock invert mismatch");

    property p_phase;
        @(posedge i_clk) disable iff (i_reset)
        i_clk_en |=> o_out_clk_phase_delay == $past(timing_reg[2:1]);
    endproperty
    a_phase: assert property (p_phase)
        else $error("phase delay mismatch");

    property p_hiz;
        @(posedge i_clk) disable iff (i_reset)
        (s_wr_outmode ##0 wr_data[2]) ##1 i_clk_en
            |=> o_outputs_high_z;
    endproperty
    a_hiz: assert property (p_hiz)
        else $error("outputs not disabled");

    property p_term;
        @(posedge i_clk) disable iff (i_reset)
        i_clk_en && outmode_reg[3] && outmode_reg[6:4] == 3'h0
            |=> o_drive_current_q == 13'h0070;
    endproperty
    a_term: assert property (p_term)
        else $error("termination scaling wrong");
endmodule // atomr_regs
`default_nettype wire

// ---- sim/atomr_host.sv ----
// serial host model that frames 16-bit mode register words
// assumes the bench feeds back the sdo line with its pull-up resolved
`timescale 1ns/1ps
`default_nettype none
module atomr_host (
    input  wire logic i_sdo_line,
    input  wire logic i_slow,
    output logic      o_ser_clk,
    output logic      o_ser_cs_n,
    output logic      o_ser_sdi
);
    initial begin
        o_ser_clk  = 1'b0;
        o_ser_cs_n = 1'b0;
        o_ser_sdi  = 1'b0;
        // a clean rising select clears the port's frame state
        #1 o_ser_cs_n = 1'b1;
    end
    // ****************************************************************
    // one frame; clock stands still outside frames
    // ****************************************************************
    task automatic xfer(input logic rw, input logic [6:0] addr,
                        input logic [7:0] data, input int nbits,
                        output logic [7:0] rd);
        logic [15:0] word;
        word = {rw, addr, data};
        rd = 8'h00;
        // slow only shifts the frame's phase; the period stays 6 ns
        #(i_slow ? 7.3 : 1.3) o_ser_cs_n = 1'b0;
        for (int i = 0; i < nbits; i++) begin
            o_ser_sdi = (i < 16) ? word[15 - i] : ~o_ser_sdi;
            #3 o_ser_clk = 1'b1;
            if (i >= 8 && i < 16) rd = {rd[6:0], i_sdo_line};
            #3 o_ser_clk = 1'b0;
        end
        #3 o_ser_cs_n = 1'b1;
        // released line: no pull, so show the inverse, not the last bit
        o_ser_sdi = ~o_ser_sdi;
        // spacing keeps 16th edges well over six system clocks apart
        #250;
    endtask
endmodule // atomr_host
`default_nettype wire

// ---- sim/adc_timing_output_mode_regs_tb.sv ----
// self-checking bench for the timing and output mode registers
// assumes package, map header, design and host model compiled first
`timescale 1ns/1ps
`default_nettype none
module adc_timing_output_mode_regs_tb import atomr_pkg::*;;
    logic        clk, reset, clk_en, slow;
    wire logic   ser_clk, cs_n, sdi, sdo_line;
    logic        sdo_out, sdo_oe, inv, stab, term, hiz, pwd, fu, cu;
    logic [1:0]  phase, fmt;
    logic [2:0]  cur;
    logic [12:0] drive, e;
    int          failures, num_checks, seed, k, c;
    atomr_byte_t timing_m, outmode_m, rd, d;
    assign sdo_line = sdo_oe ? sdo_out : 1'b1;
    always #12.5 clk = ~clk;
    atomr_regs uut (.i_clk(clk), .i_reset(reset), .i_clk_en(clk_en),
        .i_ser_clk(ser_clk), .i_ser_cs_n(cs_n), .i_ser_sdi(sdi),
        .o_sdo_out(sdo_out), .o_sdo_oe(sdo_oe), .o_out_clk_invert(inv),
        .o_out_clk_phase_delay(phase), .o_duty_cycle_stabilizer_en(stab),
        .o_diff_driver_current_sel(cur), .o_internal_termination_en(term),
        .o_outputs_high_z(hiz), .o_output_format_sel(fmt),
        .o_drive_current_q(drive), .o_phase_without_stab(pwd),
        .o_format_unused(fu), .o_current_unused(cu));
    atomr_host host (.i_sdo_line(sdo_line), .i_slow(slow),
        .o_ser_clk(ser_clk), .o_ser_cs_n(cs_n), .o_ser_sdi(sdi));
    // ****************************************************************
    // model and compare tasks
    // ****************************************************************
    function automatic int cur_ma(input logic [2:0] s);
        case (s)
            3'h1: return 80;
            3'h2: return 90;
            3'h4: return 60;
            3'h5: return 50;
            3'h6: return 42;
            3'h7: return 35;
            default: return 70;
        endcase
    endfunction
    task automatic chk(input logic [12:0] got, input logic [12:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check_outs();
        c = cur_ma(outmode_m[6:4]);
        if (outmode_m[3]) c = c * 16 / 10;
        e = {10'h0, timing_m[2:1] != 2'b00 && !timing_m[0],
             outmode_m[1:0] == 2'b11, outmode_m[6:4] == 3'b011};
        chk({9'h0, inv, phase, stab}, {9'h0, timing_m[3:0]});
        chk({6'h0, cur, term, hiz, fmt}, {6'h0, outmode_m[6:0]});
        chk(drive, c[12:0]);
        chk({10'h0, pwd, fu, cu}, e);
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] v, input int n);
        host.xfer(1'b0, a, v, n, rd);
        if (n < 16) return;
        if (a == 7'h02) timing_m = v & 8'h0f;
        if (a == 7'h03) outmode_m = v & 8'h7f;
        if (a == 7'h00 && v[7]) begin
            timing_m = 8'h00;
            outmode_m = 8'h00;
        end
    endtask
    task automatic rb(input logic [6:0] a, input logic [7:0] exp);
        d = 8'($random(seed));
        host.xfer(1'b1, a, d, 16, rd);
        chk({5'h0, rd}, {5'h0, exp});
    endtask
    task automatic test_done();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // ****************************************************************
    // scenarios
    // ****************************************************************
    initial begin
        clk = 1'b0;
        reset = 1'b0;
        clk_en = 1'b1;
        slow = 1'b0;
        seed = 83;
        failures = 0;
        num_checks = 0;
        timing_m = 8'h00;
        outmode_m = 8'h00;
        // rise at 1 ns so every asynchronous reset sees an edge
        #1 reset = 1'b1;
        repeat (8) @(negedge clk);
        reset = 1'b0;
        repeat (2) @(negedge clk);
        check_outs();
        rb(7'h02, 8'h00);
        rb(7'h03, 8'h00);
        $display("test reset values done");
        for (k = 0; k < 24; k++) begin
            d = 8'($random(seed));
            slow = d[7];
            d = 8'($random(seed));
            if (d[2:1] != 2'b00) d[0] = 1'b1;
            wr(k[0] ? 7'h02 : 7'h03, d, 16);
            check_outs();
            rb(7'h02, timing_m);
            rb(7'h03, outmode_m);
        end
        slow = 1'b0;
        $display("test random writes done");
        for (k = 0; k < 16; k++) begin
            wr(7'h03, {1'b1, k[2:0], k[3], k[0], k[1:0]}, 16);
            check_outs();
        end
        $display("test code sweep done");
        wr(7'h02, 8'h0b, 16);
        wr(7'h02, 8'h00, 10);
        wr(7'h05, 8'hff, 16);
        rb(7'h02, 8'h0b);
        wr(7'h03, 8'h25, 20);
        check_outs();
        wr(7'h02, 8'h04, 16);
        check_outs();
        $display("test refused frames done");
        wr(7'h00, 8'h80, 16);
        check_outs();
        rb(7'h02, 8'h00);
        // frame lands while frozen; write must wait for the enable
        @(negedge clk);
        clk_en = 1'b0;
        host.xfer(1'b0, 7'h02, 8'h09, 16, rd);
        check_outs();
        @(negedge clk);
        clk_en = 1'b1;
        timing_m = 8'h09;
        repeat (6) @(negedge clk);
        check_outs();
        rb(7'h02, 8'h09);
        $display("test clock enable done");
        wr(7'h03, 8'h7f, 16);
        @(negedge clk);
        reset = 1'b1;
        timing_m = 8'h00;
        outmode_m = 8'h00;
        repeat (2) @(negedge clk);
        check_outs();
        reset = 1'b0;
        repeat (2) @(negedge clk);
        check_outs();
        $display("test resets done");
        test_done();
    end
    initial begin
        #100000;
        failures++;
        test_done();
    end
endmodule // adc_timing_output_mode_regs_tb
`default_nettype wire
